// ==== src/hbp_port.sv ====
// Contract
// - type 1 little endian: both enables 16-bit, low enable even byte, upper odd
// - type 1 big endian: low-byte access is odd byte, high-byte access even
// - type 1 read is read strobe low, write high; enables pick lanes
// - address bit zero ignored (here every ADDRESS bit, bit zero included, indexes the word store); lanes chosen only by enables or byte strobes
// - type 2: byte write strobes pick lanes; read strobe alone reads 16 bits
// - without wait read data valid by wait length plus 29 ns
// - wait mode: wait driven low soon after a byte write strobe falls
// - wait mode: wait driven low soon after the read strobe falls
// - wait released to high impedance soon after the read strobe rises
// - wait released to high impedance soon after a write strobe rises
// - read data valid soon after wait returns high
// - read data valid soon after strobe falls when wait is not used
// - data bus driven only during a read, held briefly, then released
// - clock-counted limits use the system clock period
// - type 1 wait mode: wait low soon after the single write strobe falls
`timescale 1ns/100ps
module hbp_port #(
    parameter int ADDR_W = hbp_pkg::ADDR_W_DEF,
    parameter logic [7:0] WAIT_LEN = hbp_pkg::WAIT_LEN_DEF
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CHIP_SELECT_N,
    input wire logic WRITE_STROBE_N,
    input wire logic UPPER_WRITE_STROBE_N,
    input wire logic LOWER_WRITE_STROBE_N,
    input wire logic READ_STROBE_N,
    input wire logic UPPER_BYTE_ENABLE_N,
    input wire logic LOWER_BYTE_ENABLE_N,
    input wire logic [ADDR_W-1:0] ADDRESS,
    input wire logic [15:0] DATA_IN,
    output logic [15:0] DATA_OUT,
    output logic DATA_OE,
    output logic WAIT_N_OUT,
    output logic WAIT_OE,
    input wire logic CFG_TYPE2,
    input wire logic CFG_BIG_ENDIAN,
    input wire logic CFG_WAIT_EN,
    output logic CFG_READY
);
    localparam int SW = 7 + ADDR_W + 16 + 3;
    localparam logic [SW-1:0] SYNC_RST = {7'h7F, {(SW-7){1'b0}}};

    logic [SW-1:0] pins_raw;
    logic [SW-1:0] pins_s;

    wire cs_s;
    wire we_s;
    wire uwe_s;
    wire lwe_s;
    wire rd_s;
    wire hi_en_s;
    wire lo_en_s;
    wire [ADDR_W-1:0] addr_s;
    wire [15:0] din_s;
    wire type2_s;
    wire big_s;
    wire waiten_s;

    // strobes and straps all pass the two-flop synchroniser
    assign pins_raw = {CHIP_SELECT_N, WRITE_STROBE_N, UPPER_WRITE_STROBE_N,
                       LOWER_WRITE_STROBE_N, READ_STROBE_N, UPPER_BYTE_ENABLE_N,
                       LOWER_BYTE_ENABLE_N, ADDRESS, DATA_IN,
                       CFG_TYPE2, CFG_BIG_ENDIAN, CFG_WAIT_EN};

    hbp_sync #(
        .W(SW),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk(CLK),
        .rst_n(RESETN),
        .d(pins_raw),
        .q(pins_s)
    );

    assign {cs_s, we_s, uwe_s, lwe_s, rd_s, hi_en_s, lo_en_s,
            addr_s, din_s, type2_s, big_s, waiten_s} = pins_s;

    // straps
    logic [1:0] cfg_cnt_q;
    logic [1:0] cfg_cnt_d;
    logic cfg_done_q;
    logic type2_q;
    logic big_q;
    logic waiten_q;

    assign cfg_cnt_d = (cfg_cnt_q == hbp_pkg::CFG_SETTLE) ? cfg_cnt_q : cfg_cnt_q + 2'h1;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_cnt_q <= 2'h0;
            cfg_done_q <= 1'b0;
            type2_q <= 1'b0;
            big_q <= 1'b0;
            waiten_q <= 1'b0;
        end else begin
            cfg_cnt_q <= cfg_cnt_d;
            if (!cfg_done_q && cfg_cnt_q == hbp_pkg::CFG_SETTLE) begin
                cfg_done_q <= 1'b1;
                type2_q <= type2_s;
                big_q <= big_s;
                waiten_q <= waiten_s;
            end
        end
    end

    // decode of the synchronised pins
    wire sel = cfg_done_q & ~cs_s;
    wire wr_lo = type2_q ? ~lwe_s : ~lo_en_s;
    wire wr_hi = type2_q ? ~uwe_s : ~hi_en_s;
    wire wr_act = sel & (type2_q ? (~uwe_s | ~lwe_s) : ~we_s);
    wire rd_act = sel & ~rd_s & ~wr_act;
    wire [1:0] wr_lanes = {wr_hi, wr_lo};
    wire [1:0] rd_lanes = type2_q ? 2'h3 : {~hi_en_s, ~lo_en_s};

    hbp_pkg::hbp_state_e state_q;
    hbp_pkg::hbp_state_e state_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [1:0] lanes_q;
    logic [1:0] lanes_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [15:0] wdata_q;
    logic [15:0] wdata_d;
    logic [15:0] dout_q;
    logic [15:0] dout_d;
    logic doe_q;
    logic doe_d;
    logic wait_n_q;
    logic wait_n_d;
    logic wait_oe_q;
    logic wait_oe_d;
    logic mem_we;
    logic mem_re;
    logic [15:0] mem_rdata;

    // endian lane swap between pins and word storage
    wire [1:0] mem_be = big_q ? {lanes_q[0], lanes_q[1]} : lanes_q;
    wire [15:0] mem_wdata = big_q ? {wdata_q[7:0], wdata_q[15:8]} : wdata_q;
    wire [15:0] rd_swap = big_q ? {mem_rdata[7:0], mem_rdata[15:8]} : mem_rdata;
    wire [15:0] rd_pins = rd_swap & {{8{lanes_q[1]}}, {8{lanes_q[0]}}};

    wire wr_state = (state_q == hbp_pkg::HBP_WR_WAIT) || (state_q == hbp_pkg::HBP_WR_HOLD);
    wire cnt_zero = (cnt_q == 8'h00);

    assign mem_we = wr_state & ~wr_act;
    assign mem_re = (state_q == hbp_pkg::HBP_RD_WAIT) & rd_act & cnt_zero;

    hbp_mem #(
        .AW(ADDR_W)
    ) u_mem (
        .clk(CLK),
        .wr_en(mem_we),
        .wr_be(mem_be),
        .addr(addr_q),
        .wr_data(mem_wdata),
        .rd_en(mem_re),
        .rd_data(mem_rdata)
    );

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        lanes_d = lanes_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        dout_d = dout_q;
        doe_d = doe_q;
        wait_n_d = wait_n_q;
        wait_oe_d = wait_oe_q;
        case (state_q)
            hbp_pkg::HBP_IDLE: begin
                if (wr_act) begin
                    addr_d = addr_s;
                    lanes_d = wr_lanes;
                    wdata_d = din_s;
                    cnt_d = WAIT_LEN;
                    wait_n_d = 1'b0;
                    wait_oe_d = waiten_q;
                    state_d = waiten_q ? hbp_pkg::HBP_WR_WAIT : hbp_pkg::HBP_WR_HOLD;
                end else if (rd_act) begin
                    addr_d = addr_s;
                    lanes_d = rd_lanes;
                    cnt_d = WAIT_LEN;
                    doe_d = 1'b1;
                    wait_n_d = 1'b0;
                    wait_oe_d = waiten_q;
                    state_d = hbp_pkg::HBP_RD_WAIT;
                end
            end
            hbp_pkg::HBP_WR_WAIT: begin
                if (!wr_act) begin
                    wait_oe_d = 1'b0;
                    wait_n_d = 1'b1;
                    state_d = hbp_pkg::HBP_IDLE;
                end else begin
                    wdata_d = din_s;
                    lanes_d = lanes_q | wr_lanes;
                    if (cnt_zero) begin
                        wait_n_d = 1'b1;
                        state_d = hbp_pkg::HBP_WR_HOLD;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
            end
            hbp_pkg::HBP_WR_HOLD: begin
                if (!wr_act) begin
                    wait_oe_d = 1'b0;
                    wait_n_d = 1'b1;
                    state_d = hbp_pkg::HBP_IDLE;
                end else begin
                    wdata_d = din_s;
                    lanes_d = lanes_q | wr_lanes;
                end
            end
            hbp_pkg::HBP_RD_WAIT: begin
                if (!rd_act) begin
                    wait_oe_d = 1'b0;
                    wait_n_d = 1'b1;
                    cnt_d = hbp_pkg::DATA_HOLD_CNT;
                    state_d = hbp_pkg::HBP_RD_HOLD;
                end else if (cnt_zero) begin
                    state_d = hbp_pkg::HBP_RD_LOAD;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            hbp_pkg::HBP_RD_LOAD: begin
                dout_d = rd_pins;
                wait_n_d = 1'b1;
                state_d = hbp_pkg::HBP_RD_DATA;
            end
            hbp_pkg::HBP_RD_DATA: begin
                if (!rd_act) begin
                    wait_oe_d = 1'b0;
                    cnt_d = hbp_pkg::DATA_HOLD_CNT;
                    state_d = hbp_pkg::HBP_RD_HOLD;
                end
            end
            hbp_pkg::HBP_RD_HOLD: begin
                wait_oe_d = 1'b0;
                if (cnt_zero) begin
                    doe_d = 1'b0;
                    state_d = hbp_pkg::HBP_IDLE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                doe_d = 1'b0;
                wait_oe_d = 1'b0;
                wait_n_d = 1'b1;
                state_d = hbp_pkg::HBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= hbp_pkg::HBP_IDLE;
            cnt_q <= 8'h00;
            lanes_q <= 2'h0;
            addr_q <= '0;
            wdata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            lanes_q <= lanes_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            dout_q <= 16'h0000;
            doe_q <= 1'b0;
            wait_n_q <= 1'b1;
            wait_oe_q <= 1'b0;
        end else begin
            dout_q <= dout_d;
            doe_q <= doe_d;
            wait_n_q <= wait_n_d;
            wait_oe_q <= wait_oe_d;
        end
    end

    assign DATA_OUT = dout_q;
    assign DATA_OE = doe_q;
    assign WAIT_N_OUT = wait_n_q;
    assign WAIT_OE = wait_oe_q;
    assign CFG_READY = cfg_done_q;

endmodule

// ==== src/hbp_pkg.sv ====
package hbp_pkg;

    localparam int CLK_MHZ = 50;

    // data hold after the read strobe rises: a least time, rounded up
    localparam int DATA_HOLD_NS = 2;
    localparam int DATA_HOLD_RAW = (DATA_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int DATA_HOLD_CYC = (DATA_HOLD_RAW < 1) ? 1 : DATA_HOLD_RAW;
    localparam logic [7:0] DATA_HOLD_CNT = 8'(DATA_HOLD_CYC);

    // wait length in system clocks
    localparam logic [7:0] WAIT_LEN_DEF = 8'h04;

    // cycles after reset release before the straps are taken
    localparam logic [1:0] CFG_SETTLE = 2'h3;

    localparam int ADDR_W_DEF = 17;
    localparam int DATA_W = 16;

    typedef enum logic [2:0] {
        HBP_IDLE    = 3'b000,
        HBP_WR_WAIT = 3'b001,
        HBP_WR_HOLD = 3'b010,
        HBP_RD_WAIT = 3'b011,
        HBP_RD_LOAD = 3'b100,
        HBP_RD_DATA = 3'b101,
        HBP_RD_HOLD = 3'b110
    } hbp_state_e;

endpackage

// ==== src/hbp_sync.sv ====
`timescale 1ns/100ps
module hbp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // two flops per bit, reset to the idle level of each pin
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q[i] <= RST_VAL[i];
                q[i] <= RST_VAL[i];
            end else begin
                meta_q[i] <= d[i];
                q[i] <= meta_q[i];
            end
        end
    end
endmodule

// ==== src/hbp_mem.sv ====
`timescale 1ns/100ps
module hbp_mem #(
    parameter int AW = 17
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [1:0] wr_be,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic rd_en,
    output logic [15:0] rd_data
);
    logic [15:0] mem [0:(2**AW)-1];
    logic [15:0] wr_mask;

    // one write lane per byte, merged so a single process owns the array
    for (genvar b = 0; b < 2; b++) begin : g_lane
        assign wr_mask[8*b +: 8] = {8{wr_be[b]}};
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= (mem[addr] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[addr];
        end
    end
endmodule

// ==== verification/hbp_port_monitor.sv ====
`timescale 1ns/100ps
module hbp_port_monitor #(
    parameter logic [7:0] WAIT_LEN = 8'h04
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CHIP_SELECT_N,
    input wire logic WRITE_STROBE_N,
    input wire logic UPPER_WRITE_STROBE_N,
    input wire logic LOWER_WRITE_STROBE_N,
    input wire logic READ_STROBE_N,
    input wire logic DATA_OE,
    input wire logic WAIT_N_OUT,
    input wire logic WAIT_OE,
    input wire logic CFG_TYPE2,
    input wire logic CFG_WAIT_EN,
    input wire logic CFG_READY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    wire logic wr_n = CFG_TYPE2 ? (UPPER_WRITE_STROBE_N & LOWER_WRITE_STROBE_N) : WRITE_STROBE_N;
    wire logic armed = CFG_READY && CFG_WAIT_EN && !CHIP_SELECT_N;
    logic [7:0] wait_cnt_q;
    wire logic [7:0] wait_cnt_d = (WAIT_OE && !WAIT_N_OUT) ? wait_cnt_q + 8'h01 : 8'h00;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wait_cnt_q <= 8'h00;
        end else begin
            wait_cnt_q <= wait_cnt_d;
        end
    end
    a_wait_low_single: assert property (armed && !CFG_TYPE2 && $fell(WRITE_STROBE_N)
        |-> ##[1:4] (WAIT_OE && !WAIT_N_OUT)) else $error("wait not raised on write");
    a_wait_low_byte: assert property (armed && CFG_TYPE2 && $fell(wr_n)
        |-> ##[1:4] (WAIT_OE && !WAIT_N_OUT)) else $error("wait not raised on byte write");
    a_wait_low_read: assert property (armed && $fell(READ_STROBE_N)
        |-> ##[1:4] (WAIT_OE && !WAIT_N_OUT)) else $error("wait not raised on read");
    a_wait_off_read: assert property ($rose(READ_STROBE_N) && WAIT_OE
        |-> ##[1:4] !WAIT_OE) else $error("wait kept after read");
    a_wait_off_write: assert property ($rose(wr_n) && WAIT_OE
        |-> ##[1:4] !WAIT_OE) else $error("wait kept after write");
    a_wait_span_bound: assert property (wait_cnt_q <= WAIT_LEN + 8'h02)
        else $error("wait held too long");
    a_data_in_read: assert property ($rose(DATA_OE) |-> !READ_STROBE_N)
        else $error("data driven outside read");
    a_data_hold_time: assert property ($rose(READ_STROBE_N) && DATA_OE |=> DATA_OE)
        else $error("data not held");
    a_data_release_bus: assert property ($rose(READ_STROBE_N) |-> ##[1:6] !DATA_OE)
        else $error("data bus not released");
    a_nowait_quiet: assert property (CFG_READY && !CFG_WAIT_EN |-> !WAIT_OE)
        else $error("wait driven in no-wait mode");
    a_idle_before_ready: assert property (!CFG_READY |-> !DATA_OE && !WAIT_OE)
        else $error("pins driven before straps taken");
    c_wait_end: cover property (WAIT_OE && $rose(WAIT_N_OUT));
    c_type2_read: cover property ($rose(DATA_OE) && CFG_TYPE2);
    c_nowait_read: cover property ($rose(DATA_OE) && !CFG_WAIT_EN);
endmodule
bind hbp_port hbp_port_monitor #(.WAIT_LEN(WAIT_LEN)) hbp_port_monitor_i (.CLK, .RESETN,
    .CHIP_SELECT_N, .WRITE_STROBE_N, .UPPER_WRITE_STROBE_N, .LOWER_WRITE_STROBE_N,
    .READ_STROBE_N, .DATA_OE, .WAIT_N_OUT, .WAIT_OE, .CFG_TYPE2, .CFG_WAIT_EN, .CFG_READY);

// ==== verification/hbp_host_model.sv ====
`timescale 1ns/100ps
module hbp_host_model #(
    parameter logic [7:0] WAIT_LEN = 8'h04
) (
    input wire logic clk,
    input wire logic type2,
    input wire logic wait_en,
    output logic cs_n,
    output logic wr_n,
    output logic wru_n,
    output logic wrl_n,
    output logic rd_n,
    output logic hi_en_n,
    output logic lo_en_n,
    output logic [16:0] addr,
    output logic [15:0] dout,
    input wire logic [15:0] din,
    input wire logic wait_oe,
    input wire logic wait_n,
    input wire logic bus_oe
);
    // no-wait hold, a few clocks past the wait length
    localparam int HOLD_CYC = int'(WAIT_LEN) + 7;
    initial begin
        {cs_n, wr_n, wru_n, wrl_n, rd_n, hi_en_n, lo_en_n} = 7'h7F;
        addr = 17'h00000;
        dout = 16'h0000;
    end
    task automatic access(input logic wr, input logic [16:0] a, input logic [1:0] pl,
                          input logic [15:0] d, output logic [15:0] q, output logic tmo);
        int n;
        n = 0;
        @(negedge clk);
        cs_n = 1'b0;
        addr = a;
        {hi_en_n, lo_en_n} = ~pl;
        dout = wr ? d : ~d;
        if (wr) begin
            wr_n = type2;
            {wru_n, wrl_n} = type2 ? ~pl : 2'h3;
        end else begin
            rd_n = 1'b0;
        end
        // stretch by HOLD_CYC, the wait length plus seven clocks, when the wait pin is not watched
        while (n < 60 && (wait_en ? !(wait_oe && wait_n) : n < HOLD_CYC)) begin
            @(posedge clk);
            #1;
            n++;
        end
        tmo = (n >= 60);
        // a released bus reads as the inverse of the last value
        q = bus_oe ? din : ~din;
        @(negedge clk);
        {wr_n, wru_n, wrl_n, rd_n, cs_n} = 5'h1F;
        dout = ~d;
        addr = ~a;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ==== verification/tb_hbp_port.sv ====
`timescale 1ns/100ps
module tb_hbp_port;
    localparam logic [7:0] WLEN = 8'h02;
    logic CLK, RESETN, type2, big, wait_en;
    logic cs_n, wr_n, wru_n, wrl_n, rd_n, hi_en_n, lo_en_n;
    logic [16:0] addr;
    logic [15:0] dout, din, q;
    logic data_oe, wait_n, wait_oe, cfg_ready;
    logic [15:0] mem_q [4];
    logic [31:0] rng;
    int n_mismatch = 0;
    int compares = 0;

    hbp_port #(.WAIT_LEN(WLEN)) hbp_port_i (.CLK(CLK), .RESETN(RESETN), .CHIP_SELECT_N(cs_n),
        .WRITE_STROBE_N(wr_n), .UPPER_WRITE_STROBE_N(wru_n), .LOWER_WRITE_STROBE_N(wrl_n),
        .READ_STROBE_N(rd_n), .UPPER_BYTE_ENABLE_N(hi_en_n), .LOWER_BYTE_ENABLE_N(lo_en_n),
        .ADDRESS(addr), .DATA_IN(dout), .DATA_OUT(din), .DATA_OE(data_oe),
        .WAIT_N_OUT(wait_n), .WAIT_OE(wait_oe), .CFG_TYPE2(type2), .CFG_BIG_ENDIAN(big),
        .CFG_WAIT_EN(wait_en), .CFG_READY(cfg_ready));
    hbp_host_model #(.WAIT_LEN(WLEN)) hbp_host_model_i (.clk(CLK), .type2(type2),
        .wait_en(wait_en), .cs_n(cs_n), .wr_n(wr_n), .wru_n(wru_n), .wrl_n(wrl_n),
        .rd_n(rd_n), .hi_en_n(hi_en_n), .lo_en_n(lo_en_n), .addr(addr), .dout(dout),
        .din(din), .wait_oe(wait_oe), .wait_n(wait_n), .bus_oe(data_oe));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [15:0] swp(input logic [15:0] v, input logic b);
        return b ? {v[7:0], v[15:8]} : v;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one host access plus the expected effect on the word store
    task automatic op(input logic wr, input logic [1:0] a, input logic [1:0] pl,
                      input logic [15:0] d);
        logic [1:0] l;
        logic [15:0] m;
        logic tmo;
        l = (type2 && !wr) ? 2'h3 : pl;
        m = swp({{8{l[1]}}, {8{l[0]}}}, big);
        hbp_host_model_i.access(wr, {a, 15'h2B5D}, pl, d, q, tmo);
        chk({15'h0000, tmo}, 16'h0000);
        if (wr) begin
            mem_q[a] = (mem_q[a] & ~m) | (swp(d, big) & m);
        end else begin
            chk(q, swp(mem_q[a] & m, big));
        end
    endtask

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        rng = 32'h00001618;
        RESETN = 1'b0;
        {type2, big, wait_en} = 3'h0;
        for (int md = 0; md < 8; md++) begin
            @(negedge CLK);
            RESETN = 1'b0;
            {type2, big, wait_en} = md[2:0];
            repeat (4) @(negedge CLK);
            chk({13'h0000, data_oe, wait_oe, wait_n}, 16'h0001);
            RESETN = 1'b1;
            repeat (8) @(negedge CLK);
            chk({15'h0000, cfg_ready}, 16'h0001);
            if (md == 0) begin
                for (int i = 0; i < 4; i++) begin
                    rng = xs(rng);
                    op(1'b1, 2'(i), 2'h3, rng[15:0]);
                end
            end
            op(1'b1, 2'h1, 2'h1, 16'hA55A);
            op(1'b0, 2'h1, 2'h1, 16'h0000);
            op(1'b0, 2'h1, 2'h2, 16'h0000);
            op(1'b1, 2'h2, 2'h2, 16'h3CC3);
            op(1'b0, 2'h2, 2'h3, 16'h0000);
            repeat (10) begin
                rng = xs(rng);
                op(rng[0], rng[2:1], (rng[4:3] == 2'h0) ? 2'h3 : rng[4:3], rng[31:16]);
            end
        end
        give_verdict();
    end
endmodule
